/* File: hw/gga_params.svh */
// constants for the grinder, gate and alarm controller
`ifndef GGA_PARAMS_SVH
`define GGA_PARAMS_SVH

// ----------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------
`define GGA_CLK_PERIOD_NS 25
`define GGA_TICK_MS 100
`define GGA_TICK_CYCLES (`GGA_TICK_MS * 1000000 / `GGA_CLK_PERIOD_NS)
`define GGA_QUAL_MS 2000
`define GGA_QUAL_TICKS (`GGA_QUAL_MS / `GGA_TICK_MS)
`define GGA_PULSE_MS 2000
`define GGA_PULSE_TICKS (`GGA_PULSE_MS / `GGA_TICK_MS)

// ----------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------
`define GGA_ADDR_CTRL 4'h0
`define GGA_ADDR_HI_SP 4'h1
`define GGA_ADDR_LO_SP 4'h2
`define GGA_ADDR_RESTART 4'h3
`define GGA_ADDR_TRAVEL 4'h4
`define GGA_ADDR_LEVEL 4'h5
`define GGA_ADDR_ALARM 4'h6
`define GGA_ADDR_STATUS 4'h7

// ----------------------------------------------------------------
// register fields and reset values
// ----------------------------------------------------------------
`define GGA_CTRL_GATE_LSB 0
`define GGA_CTRL_GATE_MSB 3
`define GGA_CTRL_OOS_LSB 4
`define GGA_CTRL_OOS_MSB 6
`define GGA_CTRL_RST 16'h000f
`define GGA_HI_SP_RST 8'h6e
`define GGA_HI_SP_MIN 8'h50
`define GGA_HI_SP_MAX 8'ha0
`define GGA_LO_SP_RST 8'h14
`define GGA_RESTART_RST 16'h0032
`define GGA_TRAVEL_RST 16'h0258

// ----------------------------------------------------------------
// level scaling, tenths of a foot over 0 to 20 ft
// ----------------------------------------------------------------
`define GGA_RAW_ZERO 12'h333
`define GGA_RAW_LOS_MIN 12'h2e0
`define GGA_RAW_LOS_MAX 12'hffe
`define GGA_SCALE_MUL 12'hfa1
`define GGA_SCALE_SHIFT 16
`define GGA_WEIR_TENTHS 8'h64

`endif

/* File: hw/gga_pkg.sv */
// types shared by the grinder, gate and alarm controller
package gga_pkg;

    typedef struct packed {
        logic remote;
        logic running;
        logic alarm;
    } gga_grinder_fb_t;

    typedef struct packed {
        logic run;
        logic start;
        logic stop_n;
    } gga_grinder_cmd_t;

    typedef struct packed {
        logic open_lim;
        logic close_lim;
    } gga_gate_fb_t;

    typedef struct packed {
        logic open;
        logic close;
    } gga_gate_cmd_t;

    typedef enum logic [1:0] {
        GGA_ST_DOWN,
        GGA_ST_DELAY,
        GGA_ST_UP
    } gga_restart_st_t;

endpackage

/* File: hw/gga_qual.sv */
// alarm qualification timer
`timescale 1ns/1ps
`include "gga_params.svh"

module gga_qual
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // time base and condition
    input wire logic tick_i,
    input wire logic cond_i,
    // qualified alarm
    output logic alarm_o
);
    import gga_pkg::*;

    logic [7:0] cnt_q;

    // ----------------------------------------------------------------
    // persistence counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cnt_q <= 8'h00;
            alarm_o <= 1'b0;
        end
        else if (!cond_i)
        begin
            cnt_q <= 8'h00;
            alarm_o <= 1'b0;
        end
        else if (tick_i && !alarm_o)
        begin
            if (cnt_q == 8'(`GGA_QUAL_TICKS - 1))
            begin
                alarm_o <= 1'b1;
            end
            cnt_q <= cnt_q + 8'h01;
        end
    end

endmodule

/* File: hw/gga_top.sv */
// grinder, slide gate and diversion level alarm controller
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "gga_params.svh"

// Notes on behaviour
// - alarm on any network link failure
// - power loss drops all run outputs
// - restart units one by one, adjustable gap
// - link, level, float and panel alarms qualified by two second persistence
// - start contact closes two seconds only
// - stop contact open until motor stopped or run demand returns
// - level scaled 0-20 ft in tenths
// - high, low and lost-signal level alarms
// - high setpoint 8-16 ft, default 11
// - alarm on lost or out-of-range level
// - high float raises operator alarm
// - alarm when gate limit arrives late
// - read each grinder remote selector
// - start remote in-service grinders at weir
// - drop start below weir, grinder stops
// - common alarm on any grinder panel alarm
// - out of service: no start, close gate
module gga_top #(
    parameter int unsigned TICK_CYCLES = `GGA_TICK_CYCLES
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [15:0] reg_rdata_o,
    // field pins
    input wire logic power_ok_i,
    input wire logic [1:0] link_ok_i,
    input wire logic diversion_high_float_i,
    input wire gga_pkg::gga_grinder_fb_t [2:0] grinder_fb_i,
    input wire gga_pkg::gga_gate_fb_t [3:0] gate_fb_i,
    // level converter, same clock
    input wire logic [11:0] diversion_level_transmitter_i,
    // equipment commands
    output gga_pkg::gga_grinder_cmd_t [2:0] grinder_cmd_o,
    output gga_pkg::gga_gate_cmd_t [3:0] gate_cmd_o,
    // alarms and display
    output logic common_alarm_o,
    output logic operator_alarm_o,
    output logic [7:0] level_tenths_o
);
    import gga_pkg::*;

    localparam int SYNC_W = 21;
    localparam int N_ALM = 9;

    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic pwr_ok;
    logic [1:0] link_ok;
    logic float_hi;
    gga_grinder_fb_t [2:0] gr_fb;
    gga_gate_fb_t [3:0] gt_fb;
    logic [31:0] tick_cnt_q;
    logic tick_q;
    logic [15:0] ctrl_q;
    logic [7:0] hi_sp_q;
    logic [7:0] lo_sp_q;
    logic [15:0] restart_q;
    logic [15:0] travel_q;
    logic [2:0] oos;
    logic [7:0] level_q;
    logic los;
    logic [23:0] scaled;
    logic [N_ALM-1:0] alm_cond;
    logic [N_ALM-1:0] alm;
    logic [3:0] trav_alm_q;
    gga_restart_st_t rst_st_q;
    logic [6:0] en_q;
    logic [2:0] unit_q;
    logic [15:0] dly_q;
    logic [2:0] demand;
    logic [2:0] demand_q;

    // limit indication that matches the commanded direction
    function automatic logic limit_met(input gga_gate_cmd_t cmd, input gga_gate_fb_t fb);
        limit_met = (cmd.open && fb.open_lim) || (cmd.close && fb.close_lim);
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= {power_ok_i, link_ok_i, diversion_high_float_i, grinder_fb_i, gate_fb_i};
            sync2_q <= sync1_q;
        end
    end

    assign {pwr_ok, link_ok, float_hi, gr_fb, gt_fb} = sync2_q;

    // ----------------------------------------------------------------
    // 100 ms time base
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end
        else if (tick_cnt_q == TICK_CYCLES - 1)
        begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            ctrl_q <= `GGA_CTRL_RST;
            hi_sp_q <= `GGA_HI_SP_RST;
            lo_sp_q <= `GGA_LO_SP_RST;
            restart_q <= `GGA_RESTART_RST;
            travel_q <= `GGA_TRAVEL_RST;
        end
        else if (reg_we_i)
        begin
            if (reg_addr_i == `GGA_ADDR_CTRL)
            begin
                ctrl_q <= {9'h000, reg_wdata_i[`GGA_CTRL_OOS_MSB:`GGA_CTRL_GATE_LSB]};
            end
            else if (reg_addr_i == `GGA_ADDR_HI_SP)
            begin
                if (reg_wdata_i[7:0] < `GGA_HI_SP_MIN || reg_wdata_i[15:8] != 8'h00)
                begin
                    hi_sp_q <= (reg_wdata_i[15:8] != 8'h00) ? `GGA_HI_SP_MAX : `GGA_HI_SP_MIN;
                end
                else if (reg_wdata_i[7:0] > `GGA_HI_SP_MAX)
                begin
                    hi_sp_q <= `GGA_HI_SP_MAX;
                end
                else
                begin
                    hi_sp_q <= reg_wdata_i[7:0];
                end
            end
            else if (reg_addr_i == `GGA_ADDR_LO_SP)
            begin
                lo_sp_q <= reg_wdata_i[7:0];
            end
            else if (reg_addr_i == `GGA_ADDR_RESTART)
            begin
                restart_q <= reg_wdata_i;
            end
            else if (reg_addr_i == `GGA_ADDR_TRAVEL)
            begin
                travel_q <= reg_wdata_i;
            end
        end
    end

    assign oos = ctrl_q[`GGA_CTRL_OOS_MSB:`GGA_CTRL_OOS_LSB];

    // ----------------------------------------------------------------
    // register reads, data one cycle later
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || !reg_re_i)
        begin
            reg_rdata_o <= 16'h0000;
        end
        else if (reg_addr_i == `GGA_ADDR_CTRL)
        begin
            reg_rdata_o <= ctrl_q;
        end
        else if (reg_addr_i == `GGA_ADDR_HI_SP)
        begin
            reg_rdata_o <= {8'h00, hi_sp_q};
        end
        else if (reg_addr_i == `GGA_ADDR_LO_SP)
        begin
            reg_rdata_o <= {8'h00, lo_sp_q};
        end
        else if (reg_addr_i == `GGA_ADDR_RESTART)
        begin
            reg_rdata_o <= restart_q;
        end
        else if (reg_addr_i == `GGA_ADDR_TRAVEL)
        begin
            reg_rdata_o <= travel_q;
        end
        else if (reg_addr_i == `GGA_ADDR_LEVEL)
        begin
            reg_rdata_o <= {8'h00, level_q};
        end
        else if (reg_addr_i == `GGA_ADDR_ALARM)
        begin
            reg_rdata_o <= {3'h0, trav_alm_q, alm};
        end
        else if (reg_addr_i == `GGA_ADDR_STATUS)
        begin
            reg_rdata_o <= {gr_fb[2].remote, gr_fb[1].remote, gr_fb[0].remote,
                            gr_fb[2].running, gr_fb[1].running, gr_fb[0].running,
                            gt_fb, pwr_ok, (rst_st_q == GGA_ST_UP)};
        end
        else
        begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // level scaling
    // ----------------------------------------------------------------
    // lost or out of range
    assign los = (diversion_level_transmitter_i < `GGA_RAW_LOS_MIN) ||
                 (diversion_level_transmitter_i > `GGA_RAW_LOS_MAX);
    assign scaled = 24'(diversion_level_transmitter_i - `GGA_RAW_ZERO) * 24'(`GGA_SCALE_MUL);

    // tenths of a foot, last good value held
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            level_q <= 8'h00;
        end
        else if (!los)
        begin
            if (diversion_level_transmitter_i < `GGA_RAW_ZERO)
            begin
                level_q <= 8'h00;
            end
            else
            begin
                level_q <= scaled[`GGA_SCALE_SHIFT+7:`GGA_SCALE_SHIFT];
            end
        end
    end

    // ----------------------------------------------------------------
    // alarm qualification
    // ----------------------------------------------------------------
    // links, level, float, panels
    assign alm_cond = {gr_fb[2].alarm, gr_fb[1].alarm, gr_fb[0].alarm, float_hi, los,
                       (!los && level_q < lo_sp_q), (!los && level_q >= hi_sp_q), ~link_ok};

    genvar a;
    generate
        for (a = 0; a < N_ALM; a++)
        begin : g_qual
            gga_qual u_qual (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .tick_i(tick_q),
                .cond_i(alm_cond[a]),
                .alarm_o(alm[a])
            );
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            common_alarm_o <= 1'b0;
            operator_alarm_o <= 1'b0;
            level_tenths_o <= 8'h00;
        end
        else
        begin
            common_alarm_o <= |alm[8:6];
            operator_alarm_o <= (|alm) || (|trav_alm_q);
            level_tenths_o <= level_q;
        end
    end

    // ----------------------------------------------------------------
    // power restoration sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            rst_st_q <= GGA_ST_DOWN;
            en_q <= 7'h00;
            unit_q <= 3'h0;
            dly_q <= 16'h0000;
        end
        else if (!pwr_ok)
        begin
            rst_st_q <= GGA_ST_DOWN;
            en_q <= 7'h00;
            unit_q <= 3'h0;
            dly_q <= 16'h0000;
        end
        else
        begin
            case (rst_st_q)
                GGA_ST_DOWN:
                begin
                    rst_st_q <= GGA_ST_DELAY;
                    dly_q <= 16'h0000;
                end
                GGA_ST_DELAY:
                begin
                    if (dly_q >= restart_q)
                    begin
                        en_q[unit_q] <= 1'b1;
                        dly_q <= 16'h0000;
                        unit_q <= unit_q + 3'h1;
                        if (unit_q == 3'h6)
                        begin
                            rst_st_q <= GGA_ST_UP;
                        end
                    end
                    else if (tick_q)
                    begin
                        dly_q <= dly_q + 16'h0001;
                    end
                end
                default:
                begin
                    rst_st_q <= GGA_ST_UP;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // grinders
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_grinder
            logic [7:0] pulse_q;
            assign demand[g] = pwr_ok && en_q[g] && gr_fb[g].remote && !oos[g] &&
                               (level_q >= `GGA_WEIR_TENTHS);

            always_ff @(posedge clk_i)
            begin
                if (sys_rst_i)
                begin
                    demand_q[g] <= 1'b0;
                    pulse_q <= 8'h00;
                    grinder_cmd_o[g] <= '{run: 1'b0, start: 1'b0, stop_n: 1'b1};
                end
                else
                begin
                    demand_q[g] <= demand[g];
                    grinder_cmd_o[g].run <= demand[g];
                    if (demand[g] && !demand_q[g])
                    begin
                        grinder_cmd_o[g].start <= 1'b1;
                        grinder_cmd_o[g].stop_n <= 1'b1;
                        pulse_q <= 8'h00;
                    end
                    else if (!demand[g] && demand_q[g])
                    begin
                        grinder_cmd_o[g].start <= 1'b0;
                        grinder_cmd_o[g].stop_n <= 1'b0;
                    end
                    else
                    begin
                        if (grinder_cmd_o[g].start && tick_q)
                        begin
                            pulse_q <= pulse_q + 8'h01;
                            if (pulse_q == 8'(`GGA_PULSE_TICKS - 1))
                            begin
                                grinder_cmd_o[g].start <= 1'b0;
                            end
                        end
                        if (!grinder_cmd_o[g].stop_n && !gr_fb[g].running)
                        begin
                            grinder_cmd_o[g].stop_n <= 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // slide gates
    // ----------------------------------------------------------------
    genvar s;
    generate
        for (s = 0; s < 4; s++)
        begin : g_gate
            logic want_open;
            logic [15:0] trav_q;
            // out of service closes weir gate
            if (s < 3)
            begin : g_weir
                assign want_open = ctrl_q[`GGA_CTRL_GATE_LSB+s] && !oos[s];
            end
            else
            begin : g_inlet
                assign want_open = ctrl_q[`GGA_CTRL_GATE_LSB+s];
            end

            always_ff @(posedge clk_i)
            begin
                if (sys_rst_i)
                begin
                    gate_cmd_o[s] <= '{open: 1'b0, close: 1'b0};
                    trav_q <= 16'h0000;
                    trav_alm_q[s] <= 1'b0;
                end
                else
                begin
                    gate_cmd_o[s].open <= en_q[3+s] && want_open;
                    gate_cmd_o[s].close <= en_q[3+s] && !want_open;
                    if (gate_cmd_o[s].open != (en_q[3+s] && want_open) ||
                        !(gate_cmd_o[s].open || gate_cmd_o[s].close) ||
                        limit_met(gate_cmd_o[s], gt_fb[s]))
                    begin
                        trav_q <= 16'h0000;
                        trav_alm_q[s] <= 1'b0;
                    end
                    else if (trav_q >= travel_q)
                    begin
                        trav_alm_q[s] <= 1'b1;
                    end
                    else if (tick_q)
                    begin
                        trav_q <= trav_q + 16'h0001;
                    end
                end
            end
        end
    endgenerate

endmodule

/* File: verif/gga_chk.sv */
// checker for the grinder gate alarm controller
`timescale 1ns/1ps
module gga_chk #(
    parameter int unsigned TICK_CYCLES = 4
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // watched pins
    input wire logic power_ok_i,
    input wire logic diversion_high_float_i,
    input wire gga_pkg::gga_grinder_fb_t [2:0] grinder_fb_i,
    input wire gga_pkg::gga_grinder_cmd_t [2:0] grinder_cmd_o,
    input wire logic common_alarm_o,
    input wire logic operator_alarm_o,
    input wire logic [7:0] level_tenths_o
);
    import gga_pkg::*;
    localparam int QMIN = 19 * TICK_CYCLES;
    localparam int QMAX = 21 * TICK_CYCLES + 8;
    logic [15:0] gr_q;
    logic [15:0] fl_q;
    logic [15:0] st_q;
    logic any_gr;
    logic any_run;
    assign any_gr = grinder_fb_i[0].alarm | grinder_fb_i[1].alarm | grinder_fb_i[2].alarm;
    assign any_run = grinder_cmd_o[0].run | grinder_cmd_o[1].run | grinder_cmd_o[2].run;
    // ------
    // lengths of unbroken conditions
    // ------
    always_ff @(posedge clk_i)
    begin
        gr_q <= (sys_rst_i || !any_gr) ? 16'h0 : gr_q + 16'h1;
        fl_q <= (sys_rst_i || !diversion_high_float_i) ? 16'h0 : fl_q + 16'h1;
        st_q <= (sys_rst_i || !grinder_cmd_o[0].start) ? 16'h0 : st_q + 16'h1;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    sequence s_power_lost;
        !power_ok_i [*5];
    endsequence
    sequence s_below_weir;
        (level_tenths_o < 8'h64) [*3];
    endsequence
    chk_power_drop:
        assert property (s_power_lost |-> !any_run)
        else $error("run held after power loss");
    chk_weir_stop:
        assert property (s_below_weir |-> !any_run)
        else $error("run held below weir");
    chk_stop_hold:
        assert property (grinder_fb_i[0].running && !grinder_cmd_o[0].stop_n
            |=> !grinder_cmd_o[0].stop_n)
        else $error("stop closed while motor runs");
    chk_start_len:
        assert property (st_q <= QMAX)
        else $error("start closed too long");
    chk_start_full:
        assert property ($fell(grinder_cmd_o[0].start) && grinder_cmd_o[0].run
            |-> st_q >= QMIN)
        else $error("start opened early");
    chk_alarm_delay:
        assert property ($rose(common_alarm_o) |-> gr_q >= QMIN)
        else $error("alarm raised too soon");
    chk_alarm_clear:
        assert property (!any_gr [*6] |-> !common_alarm_o)
        else $error("common alarm without cause");
    chk_float_alarm:
        assert property (fl_q == QMAX |-> operator_alarm_o)
        else $error("float alarm missing");
endmodule

bind gga_top gga_chk #(.TICK_CYCLES(TICK_CYCLES)) u_gga_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .power_ok_i(power_ok_i),
    .diversion_high_float_i(diversion_high_float_i), .grinder_fb_i(grinder_fb_i),
    .grinder_cmd_o(grinder_cmd_o), .common_alarm_o(common_alarm_o),
    .operator_alarm_o(operator_alarm_o), .level_tenths_o(level_tenths_o)
);

/* File: verif/gga_field.sv */
// grinder panels and gate actuators model
`timescale 1ns/1ps
module gga_field
(
    // clock and scenario controls
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic [2:0] remote_i,
    input wire logic [2:0] fault_i,
    input wire logic [3:0] stall_i,
    // controller side
    input wire gga_pkg::gga_grinder_cmd_t [2:0] grinder_cmd_i,
    input wire gga_pkg::gga_gate_cmd_t [3:0] gate_cmd_i,
    output gga_pkg::gga_grinder_fb_t [2:0] grinder_fb_o,
    output gga_pkg::gga_gate_fb_t [3:0] gate_fb_o
);
    import gga_pkg::*;
    logic [7:0] sr_q [3] = '{default: 8'h0};
    logic [3:0] pos_q [4] = '{default: 4'h0};
    always @(posedge clk_i)
    begin
        for (int g = 0; g < 3; g++)
            sr_q[g] <= {sr_q[g][6:0], grinder_cmd_i[g].stop_n & (grinder_cmd_i[g].run
                | grinder_cmd_i[g].start)};
        for (int k = 0; k < 4; k++)
            if (!stall_i[k] && gate_cmd_i[k].open && pos_q[k] != 4'ha)
                pos_q[k] <= pos_q[k] + 4'h1;
            else if (!stall_i[k] && gate_cmd_i[k].close && pos_q[k] != 4'h0)
                pos_q[k] <= pos_q[k] - 4'h1;
    end
    always_comb
    begin
        for (int g = 0; g < 3; g++)
            grinder_fb_o[g] = {remote_i[g], slow_i ? sr_q[g][7] : sr_q[g][0], fault_i[g]};
        for (int k = 0; k < 4; k++)
            gate_fb_o[k] = {pos_q[k] == 4'ha, pos_q[k] == 4'h0};
    end
endmodule

/* File: verif/gga_top_test.sv */
// self-checking bench for the grinder gate alarm controller
`timescale 1ns/1ps
`include "gga_params.svh"
module gga_top_test;
    import gga_pkg::*;
    localparam int T = 4;
    localparam int QW = 22 * T + 6;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [15:0] reg_wdata_i = 16'h0;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    logic [15:0] reg_rdata_o;
    logic power_ok_i = 1'b0;
    logic [1:0] link_ok_i = 2'h3;
    logic float_i = 1'b0;
    logic [11:0] raw = 12'h333;
    logic slow = 1'b0;
    logic [2:0] remote = 3'h0;
    logic [2:0] fault = 3'h0;
    logic [3:0] stall = 4'h0;
    gga_grinder_fb_t [2:0] gfb;
    gga_gate_fb_t [3:0] tfb;
    gga_grinder_cmd_t [2:0] gcmd;
    gga_gate_cmd_t [3:0] tcmd;
    logic common_alarm_o;
    logic operator_alarm_o;
    logic [7:0] level_tenths_o;
    int fail_count = 0;
    int num_checks = 0;
    int seed = 82440;
    int cyc = 0;
    gga_top #(.TICK_CYCLES(T)) u_gga_top (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
        .reg_rdata_o(reg_rdata_o), .power_ok_i(power_ok_i), .link_ok_i(link_ok_i),
        .diversion_high_float_i(float_i), .grinder_fb_i(gfb), .gate_fb_i(tfb),
        .diversion_level_transmitter_i(raw), .grinder_cmd_o(gcmd), .gate_cmd_o(tcmd),
        .common_alarm_o(common_alarm_o), .operator_alarm_o(operator_alarm_o),
        .level_tenths_o(level_tenths_o)
    );
    gga_field u_gga_field (
        .clk_i(clk_i), .slow_i(slow), .remote_i(remote), .fault_i(fault), .stall_i(stall),
        .grinder_cmd_i(gcmd), .gate_cmd_i(tcmd), .grinder_fb_o(gfb), .gate_fb_o(tfb)
    );
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 12000)
        begin
            fail_count++;
            end_sim();
        end
    end
    // ------
    // bus cycles and compares
    // ------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        @(posedge clk_i);
        chk(reg_rdata_o, e);
    endtask
    function automatic logic [7:0] tenths(input logic [11:0] r);
        return 8'((r - `GGA_RAW_ZERO) * 200 / (12'hfff - `GGA_RAW_ZERO));
    endfunction
    function automatic logic on(input int u);
        return u < 3 ? gcmd[u].run : |tcmd[u - 3];
    endfunction
    // cycles between two units coming up
    task automatic gap(input int u);
        int n;
        for (n = 0; n < 300 && on(u) !== 1'b1; n++) @(posedge clk_i);
        for (n = 0; n < 300 && on(u + 1) !== 1'b1; n++) @(posedge clk_i);
        chk(16'(n), 16'(2 * T));
    endtask
    initial
    begin
        logic [15:0] v;
        logic [11:0] r;
        logic [7:0] e;
        wt(5);
        sys_rst_i <= 1'b0;
        rd(4'h0, `GGA_CTRL_RST);
        rd(4'h1, 16'(`GGA_HI_SP_RST));
        rd(4'h3, `GGA_RESTART_RST);
        rd(4'h4, `GGA_TRAVEL_RST);
        wr(4'h5, 16'h1234);
        rd(4'h5, 16'h0);
        rd(4'hc, 16'h0);
        for (int i = 0; i < 6; i++)
        begin
            v = (i == 0) ? 16'h004f : (i == 1) ? 16'h0100 : 16'($random(seed)) & 16'h00ff;
            wr(4'h1, v);
            rd(4'h1, v > 16'h00a0 ? 16'h00a0 : v < 16'h0050 ? 16'h0050 : v);
        end
        wr(4'h1, 16'h006e);
        wr(4'h3, 16'h0002);
        wr(4'h4, 16'h0005);
        power_ok_i <= 1'b1;
        gap(3);
        $display("regs and restart done");
        for (int i = 0; i < 8; i++)
        begin
            r = (i == 0) ? 12'hffe : (i == 1) ? 12'h333 : 12'h333 + 12'({$random(seed)} % 3276);
            raw <= r;
            wt(QW);
            e = tenths(r);
            chk(16'(level_tenths_o), 16'(e));
            rd(4'h6, {12'h0, e < 8'h14, e >= 8'h6e, 2'b00});
        end
        raw <= 12'h100;
        wt(QW);
        rd(4'h6, 16'h0010);
        chk(16'(level_tenths_o), 16'(e));
        raw <= 12'h666;
        float_i <= 1'b1;
        wt(40);
        float_i <= 1'b0;
        wt(1);
        float_i <= 1'b1;
        wt(40);
        chk(16'(operator_alarm_o), 16'h0);
        wt(60);
        rd(4'h6, 16'h0020);
        float_i <= 1'b0;
        $display("level alarms done");
        remote <= 3'b011;
        slow <= 1'b1;
        wr(4'h0, 16'h002f);
        raw <= 12'h9eb;
        wt(4);
        chk(16'({gcmd[2].run, gcmd[1].run, gcmd}), 16'h004f);
        chk(16'(tcmd[1]), 16'h1);
        wt(22 * T);
        chk(16'(gcmd[0]), 16'h5);
        fault <= 3'b100;
        wt(QW);
        rd(4'h6, 16'h0100);
        fault <= 3'b000;
        raw <= 12'h666;
        wt(3);
        chk(16'(gcmd[0]), 16'h0);
        wt(16);
        chk(16'(gcmd[0]), 16'h1);
        link_ok_i <= 2'b01;
        wt(QW);
        rd(4'h6, 16'h0002);
        link_ok_i <= 2'b11;
        $display("grinders done");
        stall <= 4'b0100;
        wr(4'h0, 16'h000b);
        wt(12);
        rd(4'h6, 16'h0);
        wt(130);
        rd(4'h6, 16'h0800);
        stall <= 4'b0000;
        wt(20);
        rd(4'h6, 16'h0);
        raw <= 12'h9eb;
        wt(4);
        power_ok_i <= 1'b0;
        wt(6);
        chk(16'({gcmd[0].run, gcmd[1].run, tcmd}), 16'h0);
        power_ok_i <= 1'b1;
        gap(0);
        $display("gates and power done");
        end_sim();
    end
endmodule
